//--- include/pxcs_pkg.sv
// package for the extended control and quick-poll status register slice
// assumes a 5-bit register number and 16-bit data from the management frame logic
package pxcs_pkg;
  localparam logic [4:0]  REG_PARTNER_NP    = 5'h08; // partner next-page ability
  localparam logic [4:0]  REG_RSVD_FIRST    = 5'h09; // reserved range start
  localparam logic [4:0]  REG_RSVD_LAST     = 5'h0F; // reserved range end
  localparam logic [4:0]  REG_EXT_CTRL      = 5'h10; // extended control
  localparam logic [4:0]  REG_QP_STATUS     = 5'h11; // quick-poll detailed status
  // extended control fields
  localparam int          EC_OVR_WE         = 15;
  localparam int          EC_ADDR_HI        = 10;
  localparam int          EC_ADDR_LO        = 6;
  localparam int          EC_CIPHER_TEST    = 5;
  localparam int          EC_NRZI_SEL       = 3;
  localparam int          EC_TX_INVALID     = 2;
  localparam int          EC_CIPHER_DIS     = 0;
  localparam logic        EC_NRZI_RESET     = 1'h1; // nrzi by default
  // quick-poll status fields
  localparam int          QP_RATE           = 15;
  localparam int          QP_DUPLEX         = 14;
  localparam int          QP_MON_HI         = 13;
  localparam int          QP_MON_LO         = 11;
  localparam int          NP_CODE_HI        = 3;
  localparam int          NP_CODE_LO        = 0;
  localparam logic        EC_CTRL_RESET     = 1'h0; // other control bits clear
  localparam logic [15:0] NP_CODE_MASK      = 16'h000F; // code bits of the next-page word
  localparam logic [15:0] EC_RSVD_MASK      = 16'h7812; // reserved bits of extended control
  localparam logic [15:0] QP_LOW_MASK       = 16'h07FF; // status bits kept outside this slice
  localparam logic [15:0] ZERO_WORD         = 16'h0000;
  localparam logic [3:0]  NP_CODE_RESET     = 4'h0;
  localparam logic [2:0]  MON_RESET         = 3'h0;
endpackage

//--- rtl/pxcs_regs.sv
// extended control and quick-poll detailed status registers of the phy
// assumes the management frame logic gives one-cycle read/write strobes on sys_clk
// Notes on behaviour
// - partner next-page code bits sit in bits 3..0, read-only, reset zero
// - registers nine to fifteen are reserved and have no function
// - extended control holds override enable, phy address, cipher test, nrzi, invalid, cipher off
// - quick-poll bit 15 reports rate: zero 10 Mbps, one 100 Mbps
// - quick-poll bit 14 reports duplex; one full, zero half
// - progress monitor bits two and one are latched read-only, reset zero
// - progress monitor bit zero is the low bit of that latched field
`timescale 1ns/10ps
module pxcs_regs
  import pxcs_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic [4:0]  phy_addr,
  input  wire logic        np_valid,
  input  wire logic [3:0]  np_code,
  input  wire logic        rate_100,
  input  wire logic        full_duplex,
  input  wire logic        mon_valid,
  input  wire logic [2:0]  mon_code,
  input  wire logic        override_done,
  output logic [15:0]      reg_rdata,
  output logic             override_we,
  output logic             cipher_test,
  output logic             nrzi_sel,
  output logic             tx_invalid,
  output logic             cipher_dis
);

  logic [3:0]  np_bits;
  logic [2:0]  mon_bits;
  logic        rate_bit;
  logic        dpx_bit;
  logic [4:0]  addr_meta;
  logic [4:0]  addr_bits;
  logic [3:0]  next_np_bits;
  logic [2:0]  next_mon_bits;
  logic        next_override_we;
  logic        next_cipher_test;
  logic        next_nrzi_sel;
  logic        next_tx_invalid;
  logic        next_cipher_dis;
  logic [15:0] next_reg_rdata;
  logic        ec_write;

  assign ec_write = reg_wr && (reg_addr == REG_EXT_CTRL);

  // next state for control and captured status
  always_comb begin
    next_np_bits     = np_valid ? np_code : np_bits;
    next_mon_bits    = mon_valid ? mon_code : mon_bits;
    next_cipher_test = cipher_test;
    next_nrzi_sel    = nrzi_sel;
    next_tx_invalid  = tx_invalid;
    next_cipher_dis  = cipher_dis;
    next_override_we = override_done ? 1'h0 : override_we;
    if (ec_write) begin
      next_override_we = reg_wdata[EC_OVR_WE];
      next_cipher_test = reg_wdata[EC_CIPHER_TEST];
      next_nrzi_sel    = reg_wdata[EC_NRZI_SEL];
      next_tx_invalid  = reg_wdata[EC_TX_INVALID];
      next_cipher_dis  = reg_wdata[EC_CIPHER_DIS];
    end
  end

  // reserved register numbers, shared by the read mux and its check
  function automatic logic is_rsvd_reg(input logic [4:0] num);
    is_rsvd_reg = (num >= REG_RSVD_FIRST) && (num <= REG_RSVD_LAST);
  endfunction

  // read mux; reserved and unknown numbers read zero
  always_comb begin
    next_reg_rdata = reg_rdata;
    if (reg_rd) begin
      next_reg_rdata = ZERO_WORD;
      if (reg_addr == REG_PARTNER_NP) begin
        next_reg_rdata[NP_CODE_HI:NP_CODE_LO] = np_bits;
      end else if (is_rsvd_reg(reg_addr)) begin
        next_reg_rdata = ZERO_WORD;
      end else if (reg_addr == REG_EXT_CTRL) begin
        next_reg_rdata[EC_OVR_WE]              = override_we;
        next_reg_rdata[EC_ADDR_HI:EC_ADDR_LO]  = addr_bits;
        next_reg_rdata[EC_CIPHER_TEST]         = cipher_test;
        next_reg_rdata[EC_NRZI_SEL]            = nrzi_sel;
        next_reg_rdata[EC_TX_INVALID]          = tx_invalid;
        next_reg_rdata[EC_CIPHER_DIS]          = cipher_dis;
      end else if (reg_addr == REG_QP_STATUS) begin
        next_reg_rdata[QP_RATE]              = rate_bit;
        next_reg_rdata[QP_DUPLEX]            = dpx_bit;
        next_reg_rdata[QP_MON_HI:QP_MON_LO]  = mon_bits;
      end
    end
  end

  // register stage; address straps come from pins, are static, and pass two flops
  always_ff @(posedge sys_clk) begin
    rate_bit  <= rate_100;
    dpx_bit   <= full_duplex;
    addr_meta <= phy_addr;
    addr_bits <= addr_meta;
    if (!rst_n) begin
      np_bits     <= NP_CODE_RESET;
      mon_bits    <= MON_RESET;
      override_we <= EC_CTRL_RESET;
      cipher_test <= EC_CTRL_RESET;
      nrzi_sel    <= EC_NRZI_RESET;
      tx_invalid  <= EC_CTRL_RESET;
      cipher_dis  <= EC_CTRL_RESET;
      reg_rdata   <= ZERO_WORD;
    end else begin
      np_bits     <= next_np_bits;
      mon_bits    <= next_mon_bits;
      override_we <= next_override_we;
      cipher_test <= next_cipher_test;
      nrzi_sel    <= next_nrzi_sel;
      tx_invalid  <= next_tx_invalid;
      cipher_dis  <= next_cipher_dis;
      reg_rdata   <= next_reg_rdata;
    end
  end

  a_ovr_self_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    override_done && !ec_write |=> !override_we)
    else $error("override enable did not clear");
  a_nrzi_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ec_write |=> nrzi_sel == $past(reg_wdata[EC_NRZI_SEL]))
    else $error("nrzi select not written");
  a_rsvd_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd && is_rsvd_reg(reg_addr) |=> reg_rdata == ZERO_WORD)
    else $error("reserved register not zero");
  a_np_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd && reg_addr == REG_PARTNER_NP |=> reg_rdata[NP_CODE_HI:NP_CODE_LO] == $past(np_bits))
    else $error("next-page code read wrong");
  a_mon_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !mon_valid |=> mon_bits == $past(mon_bits))
    else $error("monitor field not latched");
  a_mon_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd && reg_addr == REG_QP_STATUS |=> reg_rdata[QP_MON_HI:QP_MON_LO] == $past(mon_bits))
    else $error("monitor field read wrong");
  a_rate_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd && reg_addr == REG_QP_STATUS |=> reg_rdata[QP_RATE] == $past(rate_bit))
    else $error("rate bit read wrong");
  a_duplex_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd && reg_addr == REG_QP_STATUS |=> reg_rdata[QP_DUPLEX] == $past(dpx_bit))
    else $error("duplex bit read wrong");

  // strobe shapes that the checks below start from
  sequence s_ec_write;
    ec_write;
  endsequence
  sequence s_ec_read;
    reg_rd && reg_addr == REG_EXT_CTRL;
  endsequence
  sequence s_np_read;
    reg_rd && reg_addr == REG_PARTNER_NP;
  endsequence
  sequence s_qp_read;
    reg_rd && reg_addr == REG_QP_STATUS;
  endsequence

  // control fields take a write; a write wins over a done pulse in the same cycle
  a_ovr_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_ec_write |=> override_we == $past(reg_wdata[EC_OVR_WE]))
    else $error("override enable not written");
  a_cipher_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_ec_write |=> cipher_test == $past(reg_wdata[EC_CIPHER_TEST]))
    else $error("cipher test mode not written");
  a_txinv_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_ec_write |=> tx_invalid == $past(reg_wdata[EC_TX_INVALID]))
    else $error("invalid code enable not written");
  a_cdis_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_ec_write |=> cipher_dis == $past(reg_wdata[EC_CIPHER_DIS]))
    else $error("cipher disable not written");
  // control fields hold between writes; override enable can only clear, on a done pulse
  a_ctrl_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ec_write |=> cipher_test == $past(cipher_test) && nrzi_sel == $past(nrzi_sel)
      && tx_invalid == $past(tx_invalid) && cipher_dis == $past(cipher_dis))
    else $error("control field changed without a write");
  a_ovr_no_rise: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ec_write && !override_we |=> !override_we)
    else $error("override enable rose without a write");

  // read-back shape of the control and status words
  a_addr_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_ec_read |=> reg_rdata[EC_ADDR_HI:EC_ADDR_LO] == $past(addr_bits))
    else $error("phy address read wrong");
  a_ec_rsvd_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_ec_read |=> (reg_rdata & EC_RSVD_MASK) == ZERO_WORD)
    else $error("reserved control bit not zero");
  a_np_upper_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_np_read |=> (reg_rdata & ~NP_CODE_MASK) == ZERO_WORD)
    else $error("next-page upper bits not zero");
  a_qp_low_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_qp_read |=> (reg_rdata & QP_LOW_MASK) == ZERO_WORD)
    else $error("status bits below monitor field not zero");

  // captured status fields load on their pulse
  a_np_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
    np_valid |=> np_bits == $past(np_code))
    else $error("next-page code not captured");
  a_np_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !np_valid |=> np_bits == $past(np_bits))
    else $error("next-page code not held");
  a_mon_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mon_valid |=> mon_bits == $past(mon_code))
    else $error("monitor field not captured");

  // reset values, checked without the reset disable
  a_reset_ctrl: assert property (@(posedge sys_clk)
    !rst_n |=> override_we == EC_CTRL_RESET && cipher_test == EC_CTRL_RESET
      && nrzi_sel == EC_NRZI_RESET && tx_invalid == EC_CTRL_RESET
      && cipher_dis == EC_CTRL_RESET)
    else $error("control reset value wrong");
  a_reset_fields: assert property (@(posedge sys_clk)
    !rst_n |=> np_bits == NP_CODE_RESET && mon_bits == MON_RESET)
    else $error("status field reset value wrong");

endmodule

//--- sim/pxcs_sta.sv
// station model issuing one-cycle register strobes
// assumes the bench calls op hierarchically
`timescale 1ns/10ps
module pxcs_sta (
  input  wire logic        sys_clk,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic [4:0]       reg_addr,
  output logic [15:0]      reg_wdata
);
  initial begin
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
  end
  // one strobe cycle, address and data inverted once released
  task automatic op(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
endmodule

//--- sim/pxcs_regs_tb.sv
// self-checking bench for the extended control and quick-poll registers
// assumes the package and the station model are compiled first
`timescale 1ns/10ps
module pxcs_regs_tb
  import pxcs_pkg::*;
;
  logic        sys_clk = 1'h0, rst_n = 1'h0, reg_wr, reg_rd, np_valid = 1'h0;
  logic        rate_100 = 1'h0, full_duplex = 1'h1, mon_valid = 1'h0, override_done = 1'h0;
  logic        override_we, cipher_test, nrzi_sel, tx_invalid, cipher_dis;
  logic [4:0]  reg_addr, phy_addr = 5'h15;
  logic [15:0] reg_wdata, reg_rdata;
  logic [3:0]  np_code = 4'h0;
  logic [2:0]  mon_code = 3'h0;
  logic [15:0] ctl;
  int          errors = 0, total_checks = 0;
  assign ctl = {11'h000, override_we, cipher_test, nrzi_sel, tx_invalid, cipher_dis};
  pxcs_sta sta (.sys_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  pxcs_regs dut (.sys_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .phy_addr,
    .np_valid, .np_code, .rate_100, .full_duplex, .mon_valid, .mon_code, .override_done,
    .reg_rdata, .override_we, .cipher_test, .nrzi_sel, .tx_invalid, .cipher_dis);
  // clock and watchdog
  always #5 sys_clk = ~sys_clk;
  initial begin
    #20000;
    errors++;
    close_out();
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    sta.op(1'h1, a, d);
    @(negedge sys_clk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    sta.op(1'h0, a, 16'h0000);
    @(negedge sys_clk);
    chk(reg_rdata, exp);
  endtask
  task automatic t_reset();
    chk(ctl, 16'h0004);
    rd(REG_EXT_CTRL, 16'h0548);
    rd(REG_PARTNER_NP, 16'h0000);
    rd(REG_QP_STATUS, 16'h4000);
  endtask
  task automatic t_ctrl();
    wr(REG_EXT_CTRL, 16'h87ED); // reserved bits left zero, address bits read-only
    chk(ctl, 16'h001F);
    rd(REG_EXT_CTRL, 16'h856D);
    override_done = 1'h1;
    @(negedge sys_clk);
    override_done = 1'h0;
    @(negedge sys_clk);
    chk(ctl, 16'h000F);
    rd(REG_EXT_CTRL, 16'h056D);
    wr(REG_EXT_CTRL, 16'h0028);
    chk(ctl, 16'h000C);
    rd(REG_EXT_CTRL, 16'h0568);
    wr(REG_EXT_CTRL, 16'h0005);
    chk(ctl, 16'h0003);
    rd(REG_EXT_CTRL, 16'h0545);
    wr(REG_EXT_CTRL, 16'h0000);
    rd(REG_EXT_CTRL, 16'h0540);
  endtask
  task automatic t_np_rsvd();
    np_code = 4'hA;
    np_valid = 1'h1;
    @(negedge sys_clk);
    np_valid = 1'h0;
    np_code = 4'h5;
    wr(REG_PARTNER_NP, 16'hFFFF);
    rd(REG_PARTNER_NP, 16'h000A);
    for (int a = REG_RSVD_FIRST; a <= REG_RSVD_LAST; a++) begin
      wr(a[4:0], 16'hFFFF);
      rd(a[4:0], 16'h0000);
    end
    chk(ctl, 16'h0000);
  endtask
  // reset in mid-run with every field away from its reset value
  task automatic t_rerst();
    wr(REG_EXT_CTRL, 16'h8025);
    chk(ctl, 16'h001B);
    rst_n = 1'h0;
    repeat (6) @(negedge sys_clk);
    rst_n = 1'h1;
    chk(ctl, 16'h0004);
    rd(REG_PARTNER_NP, 16'h0000);
    rd(REG_QP_STATUS, 16'h4000);
  endtask
  task automatic t_qp(input logic r, input logic f, input logic [2:0] m, input logic [15:0] e);
    rate_100 = r;
    full_duplex = f;
    mon_code = m;
    mon_valid = 1'h1;
    @(negedge sys_clk);
    mon_valid = 1'h0;
    mon_code = ~m;
    rd(REG_QP_STATUS, e);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (6) @(negedge sys_clk);
    rst_n = 1'h1;
    t_reset();
    t_ctrl();
    t_np_rsvd();
    t_qp(1'h1, 1'h0, 3'h6, 16'hB000);
    t_qp(1'h0, 1'h1, 3'h1, 16'h4800);
    t_rerst();
    close_out();
  end
endmodule
